// >>> inc/lc_params.svh
`ifndef LC_PARAMS_SVH
`define LC_PARAMS_SVH
// register byte offsets
`define A_CTRL     8'h00
`define A_STATUS   8'h04
`define A_IRQ_STAT 8'h08
`define A_IRQ_CLR  8'h0c
`define A_IRQ_EN   8'h10
// control fields and reset value
`define CF_LATCH   0
`define CF_RR      1
`define CF_EDM_LO  2
`define CF_SCAN    4
`define CTRL_RST   5'h08
// edm modes
`define EDM_NONE   2'h0
`define EDM_ONE    2'h1
// geometry
`define N_BEAMS    16
`define N_ZONES    8
`define LAMP_CODE  10'h378
// timing
`define CLK_HZ     20000000
`define RST_MIN_MS 250
`define RST_MAX_MS 2000
`define LAMP_MS    500
`define CODE_MS    1000
`define EDM_MS     200
`define SLOT_MS    125
`endif

// >>> inc/lc_pkg.sv
package lc_pkg;
  typedef enum logic [5:0] {
    ST_LAMP    = 6'h01,
    ST_CODE    = 6'h02,
    ST_LATCH   = 6'h04,
    ST_RUN     = 6'h08,
    ST_BLOCKED = 6'h10,
    ST_LOCKOUT = 6'h20
  } state_t;
endpackage : lc_pkg

// >>> logic/light_curtain_rx.sv
`timescale 1ns/1ns
`include "lc_params.svh"
// How it works
// [RULE_01] lockout: status single-flashes red, zone and reset lamps off
// [RULE_02] emitter in normal mode shows status steady green
// [RULE_03] emitter test input open: status flashes green
// [RULE_04] latch with beams clear: red status, reset double-flash, zones green
// [RULE_05] latch mode: outputs on only when clear and after a reset
// [RULE_06] run: status green, flashing if reduced resolution; reset yellow
// [RULE_07] blocked: red status, yellow reset, red zones, blocked count shown
// [RULE_08] beam one blocked: zone one red, all other zones off
// [RULE_09] test open: display shows beam total minus one, zones red
// [RULE_10] reset is a closure held about a quarter second, under two
// [RULE_11] defaults: trip mode, two-channel check, no reduction, code one
// [RULE_12] installer selects no monitoring by tying feedback wires together; the code selects it only by EDM_NONE in ctrl[3:2]
// [RULE_13] power-up lamp test of all indicators, then scan code shown
// [RULE_14] trip turns outputs off; reduction tolerates one blocked beam
// [RULE_15] reset accepted only on release of a closure inside the window
module light_curtain_rx #(
  parameter int unsigned RST_MIN_CYC = `RST_MIN_MS*(`CLK_HZ/1000),
  parameter int unsigned RST_MAX_CYC = `RST_MAX_MS*(`CLK_HZ/1000),
  parameter int unsigned LAMP_CYC    = `LAMP_MS*(`CLK_HZ/1000),
  parameter int unsigned CODE_CYC    = `CODE_MS*(`CLK_HZ/1000),
  parameter int unsigned EDM_CYC     = `EDM_MS*(`CLK_HZ/1000),
  parameter int unsigned SLOT_CYC    = `SLOT_MS*(`CLK_HZ/1000)
) (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_b,
  // apb slave
  input  wire logic                  i_psel,
  input  wire logic                  i_penable,
  input  wire logic                  i_pwrite,
  input  wire logic [7:0]            i_paddr,
  input  wire logic [31:0]           i_pwdata,
  output logic      [31:0]           o_prdata,
  output logic                       o_pready,
  output logic                       o_pslverr,
  // optical and field pins
  input  wire logic [`N_BEAMS-1:0]   i_beam_blocked,
  input  wire logic                  i_test_open,
  input  wire logic                  i_reset_sw,
  input  wire logic                  i_fault,
  input  wire logic [1:0]            i_contactor_feedback_check,
  // machine outputs and indicators
  output logic      [1:0]            o_safety_switching_outputs,
  output logic                       o_status_red,
  output logic                       o_status_green,
  output logic                       o_reset_yellow,
  output logic      [`N_ZONES-1:0]   o_zone_red,
  output logic      [`N_ZONES-1:0]   o_zone_green,
  output logic      [9:0]            o_display,
  output logic                       o_emit_green,
  output logic                       o_emit_red,
  output logic                       o_irq
);
  localparam int SW = `N_BEAMS + 5;
  localparam logic [9:0] BEAMS_M1 = 10'(`N_BEAMS - 1);
  logic [SW-1:0] sync1, sync2;
  // pins are asynchronous to i_clk; only sync2 is read beyond here
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {i_contactor_feedback_check, i_fault, i_reset_sw,
                i_test_open, i_beam_blocked};
      sync2 <= sync1;
    end
  end
  logic [`N_BEAMS-1:0] beams;
  logic test, sw, fault;
  logic [1:0] fb;
  assign beams = sync2[`N_BEAMS-1:0];
  assign test  = sync2[`N_BEAMS];
  assign sw    = sync2[`N_BEAMS+1];
  assign fault = sync2[`N_BEAMS+2];
  assign fb    = sync2[`N_BEAMS+4:`N_BEAMS+3];

  // zone map, two beams per zone
  logic [`N_ZONES-1:0] zone_blk;
  for (genvar z = 0; z < `N_ZONES; z++) begin : g_zone
    assign zone_blk[z] = |beams[2*z +: 2];
  end

  lc_pkg::state_t state, next_state;
  logic [26:0] timer, next_timer, hold, next_hold, edm_cnt, next_edm_cnt;
  logic [26:0] blink, next_blink;
  logic [2:0]  phase, next_phase;
  logic        sw_q;
  logic [4:0]  ctrl, next_ctrl;
  logic [3:0]  irq_stat, next_irq_stat, irq_en, next_irq_en, ev;
  logic [31:0] next_prdata;
  logic        next_pready, next_pslverr, next_irq;
  logic [1:0]  next_safety_switching_outputs;
  logic        next_red, next_green, next_yel, next_egreen, next_ered;
  logic [`N_ZONES-1:0] next_zr, next_zg;
  logic [9:0]  next_disp;
  logic [4:0]  nblk;
  logic        trip, blocked, rel, rst_ok, edm_bad, setup, acc, latch, rr;

  assign latch = ctrl[`CF_LATCH];
  assign rr    = ctrl[`CF_RR];
  assign setup = i_psel & ~i_penable;
  assign acc   = i_psel & i_penable & o_pready;
  // release edge of the reset switch, judged against the hold time
  assign rel    = sw_q & ~sw;
  assign rst_ok = rel && hold >= 27'(RST_MIN_CYC)
                      && hold <= 27'(RST_MAX_CYC); // [RULE_10] [RULE_15]

  // beam count and trip decision
  always_comb begin
    nblk = '0;
    for (int b = 0; b < `N_BEAMS; b++) begin
      nblk = nblk + 5'(beams[b]);
    end
    trip    = rr ? (nblk > 5'd1) : (nblk != 5'd0); // [RULE_14]
    blocked = trip | test;
  end

  // contactor check: feedback closed means contactors dropped out
  always_comb begin
    case (ctrl[3:2])
      `EDM_NONE: edm_bad = 1'b0; // [RULE_12]
      `EDM_ONE:  edm_bad = fb[0] == o_safety_switching_outputs[0];
      default:   edm_bad = fb != ~o_safety_switching_outputs;
    endcase
  end

  // sequence, timers and events
  always_comb begin
    next_state   = state;
    next_timer   = timer + 27'd1;
    next_hold    = sw ? ((hold > 27'(RST_MAX_CYC)) ? hold : hold + 27'd1)
                      : 27'd0;
    next_edm_cnt = edm_bad ? edm_cnt + 27'd1 : 27'd0;
    next_blink   = (blink == 27'(SLOT_CYC - 1)) ? 27'd0 : blink + 27'd1;
    next_phase   = (blink == 27'(SLOT_CYC - 1)) ? phase + 3'd1 : phase;
    ev           = {rel & ~rst_ok, rst_ok, 1'b0, 1'b0};
    case (state)
      lc_pkg::ST_LAMP: begin
        if (timer == 27'(LAMP_CYC - 1)) begin
          next_state = lc_pkg::ST_CODE;
          next_timer = '0;
        end
      end
      lc_pkg::ST_CODE: begin
        if (timer == 27'(CODE_CYC - 1)) begin
          next_state = blocked ? lc_pkg::ST_BLOCKED
                     : latch ? lc_pkg::ST_LATCH : lc_pkg::ST_RUN; // [RULE_05]
        end
      end
      lc_pkg::ST_RUN: begin
        if (blocked) begin
          next_state = lc_pkg::ST_BLOCKED;
          ev[0]      = 1'b1;
        end
      end
      lc_pkg::ST_BLOCKED: begin
        if (!blocked) begin
          next_state = latch ? lc_pkg::ST_LATCH : lc_pkg::ST_RUN; // [RULE_05]
        end
      end
      lc_pkg::ST_LATCH: begin
        if (blocked) begin
          next_state = lc_pkg::ST_BLOCKED;
        end else if (rst_ok) begin
          next_state = lc_pkg::ST_RUN; // [RULE_05]
        end
      end
      lc_pkg::ST_LOCKOUT: next_state = lc_pkg::ST_LOCKOUT;
      default:            next_state = lc_pkg::ST_LOCKOUT;
    endcase
    // lockout is sticky until power is cycled, by design
    if (state != lc_pkg::ST_LOCKOUT
        && (fault || edm_cnt >= 27'(EDM_CYC))) begin
      next_state = lc_pkg::ST_LOCKOUT;
      ev[1]      = 1'b1;
    end
  end

  // indicators and outputs, registered one cycle after the state
  always_comb begin
    next_safety_switching_outputs   = (state == lc_pkg::ST_RUN && !blocked) ? 2'h3 : 2'h0;
    next_red    = 1'b1;
    next_green  = 1'b0;
    next_yel    = 1'b1;
    next_zr     = '0;
    next_zg     = '1;
    next_disp   = 10'(nblk);
    next_egreen = test ? phase[0] : 1'b1; // [RULE_02] [RULE_03]
    next_ered   = 1'b0;
    case (state)
      lc_pkg::ST_LAMP: begin
        next_red    = phase[0]; // [RULE_13]
        next_green  = phase[0];
        next_yel    = phase[0];
        next_zr     = {`N_ZONES{phase[0]}};
        next_zg     = {`N_ZONES{phase[0]}};
        next_disp   = `LAMP_CODE;
        next_egreen = phase[0];
        next_ered   = phase[0];
      end
      lc_pkg::ST_CODE: begin
        next_red  = 1'b0;
        next_yel  = 1'b0;
        next_zg   = '0;
        next_disp = ctrl[`CF_SCAN] ? 10'd2 : 10'd1; // [RULE_13]
      end
      lc_pkg::ST_LOCKOUT: begin
        next_red    = phase == 3'd0; // [RULE_01]
        next_yel    = 1'b0;
        next_zg     = '0;
        next_disp   = '0;
        next_egreen = 1'b0;
        next_ered   = phase == 3'd0;
      end
      lc_pkg::ST_LATCH: begin
        next_yel = phase == 3'd0 || phase == 3'd2; // [RULE_04]
      end
      lc_pkg::ST_RUN: begin
        next_red   = 1'b0;
        next_green = rr ? phase[0] : 1'b1; // [RULE_06]
      end
      default: begin
        next_zr = zone_blk; // [RULE_07]
        next_zg = ~zone_blk;
        if (beams[0]) begin
          next_zr = {{(`N_ZONES-1){1'b0}}, 1'b1}; // [RULE_08]
          next_zg = '0;
        end
        if (test) begin
          next_zr   = '1; // [RULE_09]
          next_zg   = '0;
          next_disp = BEAMS_M1;
        end
      end
    endcase
  end

  // apb slave: answers in the first access cycle, unmapped gives pslverr
  always_comb begin
    next_ctrl     = ctrl;
    next_irq_en   = irq_en;
    next_irq_stat = irq_stat;
    next_prdata   = '0;
    next_pready   = setup;
    next_pslverr  = 1'b0;
    if (acc && i_pwrite && i_paddr == `A_CTRL) begin
      next_ctrl = i_pwdata[4:0];
    end
    if (acc && i_pwrite && i_paddr == `A_IRQ_EN) begin
      next_irq_en = i_pwdata[3:0];
    end
    if (acc && i_pwrite && i_paddr == `A_IRQ_CLR) begin
      next_irq_stat = irq_stat & ~i_pwdata[3:0];
    end
    next_irq_stat = next_irq_stat | ev; // a new event beats the clear
    next_irq      = |(next_irq_stat & next_irq_en);
    if (setup) begin
      case (i_paddr)
        `A_CTRL:     next_prdata = {27'h0, ctrl};
        `A_STATUS:   next_prdata = {19'h0, o_safety_switching_outputs,
                                    nblk, state};
        `A_IRQ_STAT: next_prdata = {28'h0, irq_stat};
        `A_IRQ_EN:   next_prdata = {28'h0, irq_en};
        `A_IRQ_CLR:  next_prdata = '0;
        default:     next_pslverr = 1'b1;
      endcase
    end
  end

  // register everything
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state     <= lc_pkg::ST_LAMP;
      timer     <= '0;
      hold      <= '0;
      edm_cnt   <= '0;
      blink     <= '0;
      phase     <= '0;
      sw_q      <= 1'b0;
      ctrl      <= `CTRL_RST; // [RULE_11]
      irq_stat  <= '0;
      irq_en    <= '0;
      o_prdata  <= '0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_irq     <= 1'b0;
      o_safety_switching_outputs <= '0;
      o_status_red   <= 1'b0;
      o_status_green <= 1'b0;
      o_reset_yellow <= 1'b0;
      o_zone_red     <= '0;
      o_zone_green   <= '0;
      o_display      <= '0;
      o_emit_green   <= 1'b0;
      o_emit_red     <= 1'b0;
    end else begin
      state     <= next_state;
      timer     <= next_timer;
      hold      <= next_hold;
      edm_cnt   <= next_edm_cnt;
      blink     <= next_blink;
      phase     <= next_phase;
      sw_q      <= sw;
      ctrl      <= next_ctrl;
      irq_stat  <= next_irq_stat;
      irq_en    <= next_irq_en;
      o_prdata  <= next_prdata;
      o_pready  <= next_pready;
      o_pslverr <= next_pslverr;
      o_irq     <= next_irq;
      o_safety_switching_outputs <= next_safety_switching_outputs; // [RULE_14]
      o_status_red   <= next_red;
      o_status_green <= next_green;
      o_reset_yellow <= next_yel;
      o_zone_red     <= next_zr;
      o_zone_green   <= next_zg;
      o_display      <= next_disp;
      o_emit_green   <= next_egreen;
      o_emit_red     <= next_ered;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_latch_reset;
    state == lc_pkg::ST_LATCH && !blocked && rst_ok;
  endsequence
  sequence s_run_on;
    state == lc_pkg::ST_RUN ##1 o_safety_switching_outputs == 2'h3;
  endsequence
  sequence s_lamp_end;
    state == lc_pkg::ST_LAMP ##1 state == lc_pkg::ST_CODE;
  endsequence
  lockout_ind_a: assert property (state == lc_pkg::ST_LOCKOUT |=> // [RULE_01]
    !o_status_green && !o_reset_yellow && o_zone_red == '0
    && o_zone_green == '0) else $error("lockout lamps wrong");
  emit_norm_a: assert property (!test && state == lc_pkg::ST_RUN // [RULE_02]
    |=> o_emit_green) else $error("emitter not steady green");
  emit_test_a: assert property (test // [RULE_03]
    && state == lc_pkg::ST_BLOCKED
    |=> o_emit_green == $past(phase[0])) else $error("emitter no flash");
  latch_ind_a: assert property (state == lc_pkg::ST_LATCH |=> // [RULE_04]
    o_status_red && !o_status_green && o_zone_green == '1)
    else $error("latch lamps wrong");
  safety_switching_outputs_on_a: assert property ($rose(o_safety_switching_outputs[0]) // [RULE_05]
    |-> $past(state) == lc_pkg::ST_RUN && !$past(blocked))
    else $error("outputs on outside run");
  run_ind_a: assert property (state == lc_pkg::ST_RUN && !rr |=> // [RULE_06]
    o_status_green && o_reset_yellow && !o_status_red)
    else $error("run lamps wrong");
  blocked_ind_a: assert property (state == lc_pkg::ST_BLOCKED // [RULE_07]
    && !beams[0] && !test |=> o_zone_red == $past(zone_blk)
    && o_display == 10'($past(nblk))) else $error("blocked lamps wrong");
  sync_beam_a: assert property (state == lc_pkg::ST_BLOCKED // [RULE_08]
    && beams[0] && !test |=> o_zone_red == 8'h01 && o_zone_green == '0)
    else $error("beam one zones wrong");
  test_disp_a: assert property (test // [RULE_09]
    && state == lc_pkg::ST_BLOCKED
    |=> o_display == BEAMS_M1 && o_zone_red == '1)
    else $error("test display wrong");
  latch_reset_a: assert property (s_latch_reset |=> s_run_on) // [RULE_10]
    else $error("valid reset did not release outputs");
  reset_win_a: assert property (rel && hold < 27'(RST_MIN_CYC) // [RULE_15]
    |=> state != lc_pkg::ST_RUN || $past(state) == lc_pkg::ST_RUN)
    else $error("short closure accepted");
  lamp_test_a: assert property (s_lamp_end // [RULE_13]
    |-> o_display == `LAMP_CODE
    ##1 o_display == (ctrl[`CF_SCAN] ? 10'd2 : 10'd1))
    else $error("lamp test or scan code wrong");
  trip_off_a: assert property (blocked |=> // [RULE_14]
    o_safety_switching_outputs == 2'h0) else $error("trip left outputs on");
endmodule : light_curtain_rx

// >>> dv/machine_side.sv
`timescale 1ns/1ns
module machine_side (
  // clock
  input  wire logic       i_clk,
  // safety outputs of the receiver
  input  wire logic [1:0] i_outputs,
  // contactor contacts and operator switch
  output logic      [1:0] o_feedback,
  output logic            o_reset_sw
);
  logic jumper;

  initial begin
    o_feedback = 2'h3;
    o_reset_sw = 1'b0;
    jumper     = 1'b0;
  end

  // a released contactor closes its nc contact one cycle late; with the
  // checkout jumper fitted both wires read closed whatever the outputs do
  always @(posedge i_clk) begin
    o_feedback <= jumper ? 2'h3 : ~i_outputs;
  end

  // fit or remove the jumper across the two feedback wires
  task automatic tie(input logic on);
    @(posedge i_clk);
    jumper <= on;
  endtask : tie

  // switch closure to the supply for n cycles, then reopened
  task automatic press(input int n);
    @(posedge i_clk);
    o_reset_sw <= 1'b1;
    repeat (n) @(posedge i_clk);
    o_reset_sw <= 1'b0;
  endtask : press
endmodule : machine_side

// >>> dv/light_curtain_status_indication_tb.sv
`timescale 1ns/1ns
`include "lc_params.svh"
module light_curtain_status_indication_tb;
  logic               i_clk, i_rst_b, psel, pen, pwr, perr, fault, topen;
  logic [7:0]         paddr;
  logic [31:0]        pwd, prd, rd;
  logic [`N_BEAMS-1:0] beams;
  logic [1:0]         fb, safety_switching_outputs;
  logic               sw, s_red, s_grn, r_yel, e_grn, e_red, irq, rdy;
  logic [`N_ZONES-1:0] z_red, z_grn;
  logic [9:0]         disp;
  int                 fail_count, samples_checked, n;

  light_curtain_rx #(.RST_MIN_CYC(20), .RST_MAX_CYC(60), .LAMP_CYC(8),
    .CODE_CYC(8), .EDM_CYC(10), .SLOT_CYC(2)) u_dut (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd),
    .o_pready(rdy), .o_pslverr(perr), .i_beam_blocked(beams),
    .i_test_open(topen), .i_reset_sw(sw), .i_fault(fault),
    .i_contactor_feedback_check(fb), .o_safety_switching_outputs(safety_switching_outputs),
    .o_status_red(s_red), .o_status_green(s_grn), .o_reset_yellow(r_yel),
    .o_zone_red(z_red), .o_zone_green(z_grn), .o_display(disp),
    .o_emit_green(e_grn), .o_emit_red(e_red), .o_irq(irq));

  machine_side u_mach (.i_clk(i_clk), .i_outputs(safety_switching_outputs), .o_feedback(fb),
    .o_reset_sw(sw));

  // clock at 20 mhz
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // watchdog well beyond the expected run length
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    complete_run();
  end

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // apb master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge i_clk);
    psel  <= 1'b1;
    pen   <= 1'b0;
    pwr   <= w;
    paddr <= a;
    pwd   <= {27'($urandom()), d[4:0]}; // unused upper bits are noise
    @(posedge i_clk);
    pen <= 1'b1;
    // no wait count assumed; only the watchdog ends a hung access
    do @(posedge i_clk); while (rdy !== 1'b1);
    rd = prd;
    chk({31'h0, perr}, {31'h0, a > 8'h10}); // REFUSED
    // idle bus: nothing qualifies these while psel is low
    psel  <= 1'b0;
    pen   <= 1'b0;
    pwr   <= 1'($urandom());
    paddr <= 8'($urandom());
    pwd   <= $urandom();
  endtask : apb

  // count high samples of one indicator over a window of 32 cycles
  task automatic highs(input int sel, output int c);
    c = 0;
    repeat (32) begin
      @(posedge i_clk);
      case (sel)
        0: c += (s_grn === 1'b1);
        1: c += (s_red === 1'b1);
        2: c += (r_yel === 1'b1);
        3: c += (e_grn === 1'b1);
        default: c += (e_red === 1'b1);
      endcase
    end
  endtask : highs

  // behavioural model of the zone lamps, two beams per zone
  function automatic logic [7:0] exp_red(input logic [15:0] b);
    logic [7:0] z;
    z = 8'h00;
    for (int i = 0; i < 8; i++) z[i] = b[2*i] | b[2*i+1];
    return b[0] ? 8'h01 : z;
  endfunction : exp_red

  task automatic drive(input logic [15:0] b, input logic t);
    @(posedge i_clk);
    beams <= b;
    topen <= t;
    repeat (6) @(posedge i_clk);
  endtask : drive

  initial begin
    i_rst_b = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; paddr = 8'h00;
    pwd = 32'h0; beams = 16'h0; topen = 1'b0; fault = 1'b0;
    fail_count = 0;
    samples_checked = 0;
    void'($urandom(32'h024e));
    repeat (16) @(posedge i_clk);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk);
    chk(disp, `LAMP_CODE);
    apb(1'b0, `A_CTRL, 32'h0);
    chk(rd, 32'h8);
    apb(1'b0, `A_IRQ_EN, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'(8'h14 + $urandom_range(0, 235)), 32'h0);
    chk(rd, 32'h0); // REFUSED
    repeat (30) @(posedge i_clk);
    $display("test power-up done");
    // clear run in trip mode
    apb(1'b0, `A_STATUS, 32'h0);
    chk(rd & 32'h3f, 32'h08);
    chk({safety_switching_outputs, z_grn, r_yel}, {2'h3, 8'hff, 1'b1});
    highs(0, n);
    chk(n, 32);
    highs(3, n);
    chk(n, 32);
    $display("test run done");
    // random blocked patterns, sync beam clear
    apb(1'b1, `A_IRQ_EN, 32'h1);
    repeat (6) begin
      logic [15:0] b;
      b = (16'($urandom()) & 16'hfffe) | 16'h0004;
      drive(b, 1'b0);
      chk(disp, $countones(b));
      chk({z_red, s_red, r_yel, safety_switching_outputs}, {exp_red(b), 2'h3, 2'h0});
      drive(16'h0, 1'b0);
      chk(safety_switching_outputs, 2'h3);
    end
    chk(irq, 1'b1);
    apb(1'b1, `A_IRQ_CLR, 32'hf);
    repeat (2) @(posedge i_clk);
    chk(irq, 1'b0);
    apb(1'b0, `A_IRQ_STAT, 32'h0);
    chk(rd & 32'h1, 32'h0);
    $display("test blocked done");
    drive(16'h0001, 1'b0);
    chk({z_red, z_grn, safety_switching_outputs}, {8'h01, 8'h00, 2'h0});
    drive(16'h0, 1'b1);
    chk({disp, z_red}, {10'(`N_BEAMS - 1), 8'hff});
    highs(3, n);
    chk(n > 0 && n < 32, 1);
    $display("test sync and test input done");
    // reduced resolution tolerates one blocked beam
    drive(16'h0, 1'b0);
    apb(1'b1, `A_CTRL, 32'ha);
    drive(16'h0100, 1'b0);
    chk(safety_switching_outputs, 2'h3);
    highs(0, n);
    chk(n > 0 && n < 32, 1);
    drive(16'h0300, 1'b0);
    chk(safety_switching_outputs, 2'h0);
    $display("test reduced resolution done");
    // latch mode: short and long closures refused, a proper one accepted
    apb(1'b1, `A_CTRL, 32'h9);
    drive(16'h0, 1'b0);
    chk({s_red, z_grn, safety_switching_outputs}, {1'b1, 8'hff, 2'h0});
    highs(2, n);
    chk(n > 0 && n < 32, 1);
    u_mach.press(5);
    u_mach.press(80);
    repeat (8) @(posedge i_clk);
    chk(safety_switching_outputs, 2'h0);
    apb(1'b0, `A_IRQ_STAT, 32'h0);
    chk(rd & 32'hc, 32'h8);
    u_mach.press(30);
    repeat (8) @(posedge i_clk);
    chk(safety_switching_outputs, 2'h3);
    apb(1'b0, `A_IRQ_STAT, 32'h0);
    chk(rd & 32'h4, 32'h4);
    $display("test latch done");
    // checkout jumper on the feedback wires with monitoring switched off
    apb(1'b1, `A_CTRL, 32'h0);
    u_mach.tie(1'b1);
    repeat (30) @(posedge i_clk);
    chk(safety_switching_outputs, 2'h3);
    apb(1'b0, `A_STATUS, 32'h0);
    chk(rd & 32'h3f, 32'h08);
    $display("test no monitoring done");
    // internal fault forces lockout
    @(posedge i_clk);
    fault <= 1'b1;
    repeat (6) @(posedge i_clk);
    chk({safety_switching_outputs, z_red, z_grn, r_yel, e_grn}, 20'h0);
    highs(1, n);
    chk(n > 0 && n < 32, 1);
    highs(4, n);
    chk(n > 0 && n < 32, 1);
    // lockout only leaves through reset, whatever the fault pin does next
    fault <= 1'($urandom());
    apb(1'b0, `A_STATUS, 32'h0);
    chk(rd & 32'h3f, 32'h20);
    $display("test lockout done");
    complete_run();
  end
endmodule : light_curtain_status_indication_tb
